// File: logic/ssm_map.vh
// register offsets, field positions, reset values and filter counts
// assumes an 8-bit register port with a 9-bit byte address
`ifndef SSM_MAP_VH
`define SSM_MAP_VH

// register offsets
`define A_CONTROL 9'h170
`define A_RX_CODE 9'h171
`define A_MATCH_ONE 9'h172
`define A_MATCH_TWO 9'h173
`define A_MATCH_THREE 9'h174
`define A_TX_CODE 9'h175
`define A_TX_REPEAT 9'h176
`define A_RX_INTL 9'h177
`define A_TX_INTL 9'h178
`define A_SA_SELECT 9'h179
`define A_IRQ_STATUS 9'h17A
`define A_IRQ_MASK 9'h17B

// control register fields
`define B_CARRIER 7
`define B_MFILT_HI 6
`define B_MFILT_LO 5
`define B_RX_EN 4
`define B_RESET 3
`define B_RFILT_HI 2
`define B_RFILT_LO 1
`define B_SEND 0

// interrupt status and mask layout
`define E_RX_MSG 0
`define E_CHANGE 1
`define E_MATCH1 2
`define E_MATCH2 3
`define E_MATCH3 4
`define E_TX_DONE 5
`define E_WIDTH 6

// reset values
`define R_CONTROL 8'h00
`define R_REPEAT 8'h01
`define R_ZERO8 8'h00
`define R_ZERO4 4'h0
`define R_SA_SEL 3'h0

// consecutive-code filter counts
`define FILT_NONE 3'h1
`define FILT_3 3'h3
`define FILT_5 3'h5
`define FILT_7 3'h7

// quality codes
`define Q_UNKNOWN 4'h0
`define Q_PRC 4'h2
`define Q_SSU_A 4'h4
`define Q_SSU_B 4'h8
`define Q_SEC 4'hB
`define Q_DNU 4'hF

`endif

// File: logic/code_filter.v
// consecutive identical code qualifier, one pulse when the run is met
// assumes strobes are at least two clocks apart and code_in stays stable
`timescale 1ns/100ps
`include "ssm_map.vh"

module code_filter
(
   // clock and reset
   input wire mclk_in,
   input wire rst_in,
   // control
   input wire clear_in,
   input wire [1:0] sel_in,
   // assembled code
   input wire stb_in,
   input wire [3:0] code_in,
   input wire err_in,
   // result
   output wire hit_out
);

reg [3:0] last_ff;
reg [2:0] run_ff;
reg hit_ff;
reg fired_ff;
reg [2:0] need;
reg [2:0] nxt_run;
wire grow;
wire fire;

assign grow = (code_in == last_ff) && (run_ff != 3'h0);

always @*
begin
   case (sel_in)
      2'h0: need = `FILT_NONE;
      2'h1: need = `FILT_3;
      2'h2: need = `FILT_5;
      default: need = `FILT_7;
   endcase
   // an errored code breaks the run; count saturates at 7
   if (err_in)
      nxt_run = 3'h0;
   else if (grow)
      nxt_run = (run_ff == 3'h7) ? 3'h7 : run_ff + 3'h1;
   else
      nxt_run = 3'h1;
end

// fires once per run, not again while the same code keeps coming;
// a filter relaxed mid-run still lets the ongoing run through
assign fire = stb_in && !err_in && (nxt_run >= need) && !(grow && fired_ff);

always @(posedge mclk_in or posedge rst_in)
begin
   if (rst_in)
   begin
      last_ff <= 4'h0;
      run_ff <= 3'h0;
      hit_ff <= 1'b0;
      fired_ff <= 1'b0;
   end
   else if (clear_in)
   begin
      last_ff <= 4'h0;
      run_ff <= 3'h0;
      hit_ff <= 1'b0;
      fired_ff <= 1'b0;
   end
   else
   begin
      hit_ff <= fire;
      if (stb_in)
      begin
         run_ff <= nxt_run;
         last_ff <= code_in;
         fired_ff <= fire || (grow && fired_ff);
      end
   end
end

assign hit_out = hit_ff;

endmodule // code_filter

// File: logic/ssm_boc_ctrl.v
// E1 synchronization status message controller: code send and receive
// in one Sa bit or the Si bit, filters, match alarms, raw Si bits.
// assumes the framer gives one frame_tick_in per frame with the frame
// number in the crc multiframe and that frame's overhead bits beside it.
//
// Contract
// RQ1 - codes go MSB first from frame 2; receiver aligns the same way
// RQ2 - 4-bit quality code values; others reserved
// RQ3 - control bit 7 picks Sa carrier or Si carrier both directions
// RQ4 - active message overrides normal Sa; software enables one Sa only
// RQ5 - match filter needs 1/3/5/7 identical clean codes; not for alarm
// RQ6 - control bit 4 enables the receiver
// RQ7 - control bit 3 restores defaults except interrupt registers, self clears
// RQ8 - receive filter 1/3/5/7 gates alarm and receive register update
// RQ9 - control bit 0 starts a send and self clears
// RQ10 - accepted code goes to bits 3:0, old bits 3:0 move to 7:4
// RQ11 - three expected codes each with own alarm, match filtered
// RQ12 - change alarm when accepted code differs from previous one
// RQ13 - repeat code count times then all ones; 0 means forever
// RQ14 - software ends endless send by new count and new send
// RQ15 - received FAS Si bits held, updated on multiframe boundary
// RQ16 - programmed Si bits sent from boundary; message wins when enabled
// RQ17 - transmit data takes effect at boundary; reads are coherent
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`include "ssm_map.vh"

module ssm_boc_ctrl
(
   // clock and reset
   input wire mclk_in,
   input wire rst_in,
   // register port
   input wire [8:0] addr_in,
   input wire [7:0] wr_data_in,
   input wire wr_in,
   input wire rd_in,
   output wire [7:0] rd_data_out,
   // framer timing
   input wire frame_tick_in,
   input wire [3:0] frame_num_in,
   // receive overhead
   input wire [4:0] rx_sa_in,
   input wire rx_si_in,
   input wire rx_err_in,
   // transmit overhead
   output wire [4:0] tx_sa_out,
   output wire [4:0] tx_sa_ovr_out,
   output wire tx_si_out,
   // interrupt
   output wire irq_out
);

localparam ST_IDLE = 2'h0;
localparam ST_SEND = 2'h1;
localparam ST_ONES = 2'h2;

// ************************************************************
// registers
// ************************************************************
reg [7:0] control_ff;
reg [7:0] rx_code_ff;
reg [3:0] exp_one_ff;
reg [3:0] exp_two_ff;
reg [3:0] exp_three_ff;
reg [3:0] tx_code_ff;
reg [7:0] tx_repeat_ff;
reg [7:0] rx_intl_ff;
reg [7:0] tx_intl_ff;
reg [2:0] sa_sel_ff;
reg [`E_WIDTH-1:0] status_ff;
reg [`E_WIDTH-1:0] mask_ff;
reg [7:0] rd_data_ff;
reg irq_ff;

wire wr_ctl = wr_in && (addr_in == `A_CONTROL);
// RQ7 soft reset
wire soft_rst = wr_ctl && wr_data_in[`B_RESET];
// RQ9 send trigger
wire send_req = wr_ctl && wr_data_in[`B_SEND] && !wr_data_in[`B_RESET];

wire carrier_si = control_ff[`B_CARRIER];
wire rx_en = control_ff[`B_RX_EN];
wire [1:0] mfilt_sel = control_ff[`B_MFILT_HI:`B_MFILT_LO];
wire [1:0] rfilt_sel = control_ff[`B_RFILT_HI:`B_RFILT_LO];

// ************************************************************
// frame slots
// ************************************************************
// RQ3 carrier frame: Si in FAS (even) frames, Sa in NFAS (odd) frames
wire carrier_frame = frame_tick_in && (frame_num_in[0] == !carrier_si);
// RQ1 slot phase counted from frame 2
wire [3:0] from_two = frame_num_in - 4'h2;
wire [1:0] phase = from_two[2:1];
wire boundary = frame_tick_in && (frame_num_in == 4'h0);
wire fas_frame = frame_tick_in && !frame_num_in[0];
wire sa_valid = (sa_sel_ff <= 3'h4);
wire rx_bit = carrier_si ? rx_si_in : (sa_valid ? rx_sa_in[sa_sel_ff] : 1'b1);

// ************************************************************
// receive assembly
// ************************************************************
reg [2:0] rx_sh_ff;
reg rx_err_ff;
reg rx_started_ff;
reg nib_stb_ff;
reg [3:0] nib_code_ff;
reg nib_err_ff;
reg [7:0] si_sh_ff;

always @(posedge mclk_in or posedge rst_in)
begin
   if (rst_in)
   begin
      rx_sh_ff <= 3'h0;
      rx_err_ff <= 1'b0;
      rx_started_ff <= 1'b0;
      nib_stb_ff <= 1'b0;
      nib_code_ff <= 4'h0;
      nib_err_ff <= 1'b0;
   end
   // RQ6 receiver idle when disabled
   else if (soft_rst || !rx_en)
   begin
      rx_sh_ff <= 3'h0;
      rx_err_ff <= 1'b0;
      rx_started_ff <= 1'b0;
      nib_stb_ff <= 1'b0;
   end
   else
   begin
      nib_stb_ff <= 1'b0;
      if (carrier_frame)
      begin
         // RQ1 msb first, aligned on frame 2
         if (phase == 2'h0)
         begin
            rx_started_ff <= 1'b1;
            rx_err_ff <= rx_err_in;
            rx_sh_ff <= {2'h0, rx_bit};
         end
         else if (phase == 2'h3)
         begin
            nib_stb_ff <= rx_started_ff;
            nib_code_ff <= {rx_sh_ff, rx_bit};
            nib_err_ff <= rx_err_ff || rx_err_in;
         end
         else
         begin
            rx_sh_ff <= {rx_sh_ff[1:0], rx_bit};
            rx_err_ff <= rx_err_ff || rx_err_in;
         end
      end
   end
end

// ************************************************************
// filters
// ************************************************************
wire rx_hit;
wire match_hit;

// RQ8 receive filter
code_filter u_rx_filter
(
   .mclk_in(mclk_in),
   .rst_in(rst_in),
   .clear_in(soft_rst || !rx_en),
   .sel_in(rfilt_sel),
   .stb_in(nib_stb_ff),
   .code_in(nib_code_ff),
   .err_in(nib_err_ff),
   .hit_out(rx_hit)
);

// RQ5 match filter, separate from the receive filter
code_filter u_match_filter
(
   .mclk_in(mclk_in),
   .rst_in(rst_in),
   .clear_in(soft_rst || !rx_en),
   .sel_in(mfilt_sel),
   .stb_in(nib_stb_ff),
   .code_in(nib_code_ff),
   .err_in(nib_err_ff),
   .hit_out(match_hit)
);

// ************************************************************
// transmit engine
// ************************************************************
reg [1:0] tx_st_ff;
reg [1:0] nxt_tx_st;
reg [3:0] cur_code_ff;
reg [3:0] nxt_cur_code;
reg [7:0] remain_ff;
reg [7:0] nxt_remain;
reg pend_ff;
reg tx_done_ev;
reg msg_bit;
reg [4:0] tx_sa_ff;
reg [4:0] tx_sa_ovr_ff;
reg tx_si_ff;
reg [7:0] tx_si_hold_ff;

// RQ17 a pending send is taken only at the first slot of a multiframe
wire start_now = pend_ff && carrier_frame && (phase == 2'h0) && (frame_num_in[3:1] == 3'h1);

always @*
begin
   nxt_tx_st = tx_st_ff;
   nxt_cur_code = cur_code_ff;
   nxt_remain = remain_ff;
   tx_done_ev = 1'b0;
   msg_bit = 1'b1;
   if (start_now)
   begin
      nxt_tx_st = ST_SEND;
      nxt_cur_code = tx_code_ff;
      nxt_remain = tx_repeat_ff;
      msg_bit = tx_code_ff[3];
   end
   else if (carrier_frame && (tx_st_ff == ST_SEND))
   begin
      // RQ1 msb in the first slot
      msg_bit = cur_code_ff[2'h3 - phase];
      // RQ13 count repetitions, zero repeats forever
      if ((phase == 2'h3) && (remain_ff != 8'h00))
      begin
         nxt_remain = remain_ff - 8'h01;
         if (remain_ff == 8'h01)
         begin
            nxt_tx_st = ST_ONES;
            tx_done_ev = 1'b1;
         end
      end
   end
end

always @(posedge mclk_in or posedge rst_in)
begin
   if (rst_in)
   begin
      tx_st_ff <= ST_IDLE;
      cur_code_ff <= 4'h0;
      remain_ff <= 8'h00;
      pend_ff <= 1'b0;
      tx_sa_ff <= 5'h1F;
      tx_sa_ovr_ff <= 5'h00;
      tx_si_ff <= 1'b1;
      tx_si_hold_ff <= 8'h00;
   end
   else if (soft_rst)
   begin
      tx_st_ff <= ST_IDLE;
      cur_code_ff <= 4'h0;
      remain_ff <= 8'h00;
      pend_ff <= 1'b0;
      tx_sa_ff <= 5'h1F;
      tx_sa_ovr_ff <= 5'h00;
      tx_si_hold_ff <= 8'h00;
   end
   else
   begin
      tx_st_ff <= nxt_tx_st;
      cur_code_ff <= nxt_cur_code;
      remain_ff <= nxt_remain;
      // RQ14 a new send replaces an endless one
      if (send_req)
         pend_ff <= 1'b1;
      else if (start_now)
         pend_ff <= 1'b0;
      // RQ17 programmed Si bits taken at the boundary
      if (boundary)
         tx_si_hold_ff <= tx_intl_ff;
      if (frame_tick_in)
      begin
         // RQ4 override only the one selected Sa bit while active
         tx_sa_ovr_ff <= 5'h00;
         tx_sa_ff <= 5'h1F;
         if (!carrier_si && sa_valid && (nxt_tx_st != ST_IDLE))
         begin
            tx_sa_ovr_ff[sa_sel_ff] <= 1'b1;
            tx_sa_ff[sa_sel_ff] <= msg_bit;
         end
         // RQ16 message wins over programmed Si bits
         if (fas_frame)
         begin
            if (carrier_si && (nxt_tx_st != ST_IDLE))
               tx_si_ff <= msg_bit;
            else if (boundary)
               tx_si_ff <= tx_intl_ff[7];
            else
               tx_si_ff <= tx_si_hold_ff[3'h7 - frame_num_in[3:1]];
         end
      end
   end
end

// ************************************************************
// host registers
// ************************************************************
wire [3:0] cur_rx = rx_code_ff[3:0];
reg [`E_WIDTH-1:0] events;
reg [`E_WIDTH-1:0] nxt_status;

always @*
begin
   events = {`E_WIDTH{1'b0}};
   // RQ8 alarm is raised by the receive filter only
   events[`E_RX_MSG] = rx_hit;
   // RQ12 change against the last accepted code
   events[`E_CHANGE] = rx_hit && (nib_code_ff != cur_rx);
   // RQ11 each expected code has its own alarm
   events[`E_MATCH1] = match_hit && (nib_code_ff == exp_one_ff);
   events[`E_MATCH2] = match_hit && (nib_code_ff == exp_two_ff);
   events[`E_MATCH3] = match_hit && (nib_code_ff == exp_three_ff);
   events[`E_TX_DONE] = tx_done_ev;
   nxt_status = status_ff;
   if (wr_in && (addr_in == `A_IRQ_STATUS))
      nxt_status = status_ff & ~wr_data_in[`E_WIDTH-1:0];
   // set wins over a clear in the same cycle
   nxt_status = nxt_status | events;
end

always @(posedge mclk_in or posedge rst_in)
begin
   if (rst_in)
   begin
      control_ff <= `R_CONTROL;
      rx_code_ff <= `R_ZERO8;
      exp_one_ff <= `R_ZERO4;
      exp_two_ff <= `R_ZERO4;
      exp_three_ff <= `R_ZERO4;
      tx_code_ff <= `R_ZERO4;
      tx_repeat_ff <= `R_REPEAT;
      rx_intl_ff <= `R_ZERO8;
      tx_intl_ff <= `R_ZERO8;
      sa_sel_ff <= `R_SA_SEL;
      si_sh_ff <= `R_ZERO8;
      status_ff <= {`E_WIDTH{1'b0}};
      mask_ff <= {`E_WIDTH{1'b0}};
      irq_ff <= 1'b0;
   end
   else
   begin
      status_ff <= nxt_status;
      irq_ff <= |(status_ff & mask_ff);
      if (wr_in && (addr_in == `A_IRQ_MASK))
         mask_ff <= wr_data_in[`E_WIDTH-1:0];
      // RQ7 defaults back, interrupt registers kept
      if (soft_rst)
      begin
         control_ff <= `R_CONTROL;
         rx_code_ff <= `R_ZERO8;
         exp_one_ff <= `R_ZERO4;
         exp_two_ff <= `R_ZERO4;
         exp_three_ff <= `R_ZERO4;
         tx_code_ff <= `R_ZERO4;
         tx_repeat_ff <= `R_REPEAT;
         rx_intl_ff <= `R_ZERO8;
         tx_intl_ff <= `R_ZERO8;
         sa_sel_ff <= `R_SA_SEL;
         si_sh_ff <= `R_ZERO8;
      end
      else
      begin
         // RQ9 send and reset bits are not stored
         if (wr_ctl)
            control_ff <= wr_data_in & 8'hF6;
         if (wr_in && (addr_in == `A_MATCH_ONE))
            exp_one_ff <= wr_data_in[3:0];
         if (wr_in && (addr_in == `A_MATCH_TWO))
            exp_two_ff <= wr_data_in[3:0];
         if (wr_in && (addr_in == `A_MATCH_THREE))
            exp_three_ff <= wr_data_in[3:0];
         if (wr_in && (addr_in == `A_TX_CODE))
            tx_code_ff <= wr_data_in[3:0];
         if (wr_in && (addr_in == `A_TX_REPEAT))
            tx_repeat_ff <= wr_data_in;
         if (wr_in && (addr_in == `A_TX_INTL))
            tx_intl_ff <= wr_data_in;
         if (wr_in && (addr_in == `A_SA_SELECT))
            sa_sel_ff <= wr_data_in[2:0];
         // RQ2 RQ10 codes kept as received; new code low, previous high
         if (rx_hit)
            rx_code_ff <= {cur_rx, nib_code_ff};
         // RQ15 Si of FAS frames, frame 0 in bit 7
         if (fas_frame)
            si_sh_ff[3'h7 - frame_num_in[3:1]] <= rx_si_in;
         if (boundary)
            rx_intl_ff <= si_sh_ff;
      end
   end
end

// RQ17 read data sampled from flops in one edge, so never torn
always @(posedge mclk_in or posedge rst_in)
begin
   if (rst_in)
      rd_data_ff <= 8'h00;
   else if (rd_in)
   begin
      case (addr_in)
         `A_CONTROL: rd_data_ff <= control_ff;
         `A_RX_CODE: rd_data_ff <= rx_code_ff;
         `A_MATCH_ONE: rd_data_ff <= {4'h0, exp_one_ff};
         `A_MATCH_TWO: rd_data_ff <= {4'h0, exp_two_ff};
         `A_MATCH_THREE: rd_data_ff <= {4'h0, exp_three_ff};
         `A_TX_CODE: rd_data_ff <= {4'h0, tx_code_ff};
         `A_TX_REPEAT: rd_data_ff <= tx_repeat_ff;
         `A_RX_INTL: rd_data_ff <= rx_intl_ff;
         `A_TX_INTL: rd_data_ff <= tx_intl_ff;
         `A_SA_SELECT: rd_data_ff <= {5'h00, sa_sel_ff};
         `A_IRQ_STATUS: rd_data_ff <= {2'h0, status_ff};
         `A_IRQ_MASK: rd_data_ff <= {2'h0, mask_ff};
         default: rd_data_ff <= 8'h00;
      endcase
   end
   else
      rd_data_ff <= 8'h00;
end

assign rd_data_out = rd_data_ff;
assign tx_sa_out = tx_sa_ff;
assign tx_sa_ovr_out = tx_sa_ovr_ff;
assign tx_si_out = tx_si_ff;
assign irq_out = irq_ff;

endmodule // ssm_boc_ctrl

// File: verif/ssm_boc_ctrl_chk.sv
// port-level assertions for the ssm code controller
// assumes the single clock domain of the design's top module
`timescale 1ns/100ps
module ssm_boc_chk
(
   // clock and reset
   input wire mclk_in,
   input wire rst_in,
   // register port
   input wire [8:0] addr_in,
   input wire [7:0] wr_data_in,
   input wire wr_in,
   input wire rd_in,
   input wire [7:0] rd_data_out,
   // framer timing
   input wire frame_tick_in,
   input wire [3:0] frame_num_in,
   // transmit and interrupt
   input wire [4:0] tx_sa_out,
   input wire [4:0] tx_sa_ovr_out,
   input wire tx_si_out,
   input wire irq_out
);
   default clocking dflt @(posedge mclk_in);
   endclocking
   default disable iff (rst_in);

   // ****
   // steps
   // ****
   sequence ctl_rd;
      rd_in && addr_in == 9'h170;
   endsequence
   sequence soft_wr;
      wr_in && addr_in == 9'h170 && wr_data_in[3];
   endsequence
   sequence cnt_rd;
      rd_in && addr_in == 9'h176;
   endsequence

   // ****
   // rules
   // ****
   idle_read_a:
      assert property (!rd_in |=> rd_data_out == 8'h00)
      else $error("read data not zero while idle");
   unmapped_read_a:
      assert property (rd_in && (addr_in < 9'h170 || addr_in > 9'h17B) |=> rd_data_out == 8'h00)
      else $error("unmapped read not zero");
   self_clear_a:
      assert property (ctl_rd |=> rd_data_out[3] == 1'b0 && rd_data_out[0] == 1'b0)
      else $error("control action bits read back set");
   soft_reset_a:
      assert property (soft_wr ##1 !wr_in ##1 cnt_rd |=> rd_data_out == 8'h01)
      else $error("repeat count not restored by soft reset");
   reserved_zero_a:
      assert property (rd_in && addr_in >= 9'h172 && addr_in <= 9'h175 |=> rd_data_out[7:4] == 4'h0)
      else $error("reserved bits read back set");
   tx_hold_a:
      assert property (!frame_tick_in && !wr_in |=> $stable(tx_sa_out) && $stable(tx_sa_ovr_out)
         && $stable(tx_si_out))
      else $error("transmit bits moved between frames");
   one_sa_a:
      assert property ($onehot0(tx_sa_ovr_out))
      else $error("more than one national bit overridden");
   sa_rest_ones_a:
      assert property ((tx_sa_out | tx_sa_ovr_out) == 5'h1F)
      else $error("free national bit not one");
   si_fas_only_a:
      assert property (frame_tick_in && frame_num_in[0] && !wr_in |=> $stable(tx_si_out))
      else $error("international bit moved on odd frame");
   mask_off_a:
      assert property (wr_in && addr_in == 9'h17B && wr_data_in[5:0] == 6'h00 |-> ##2 !irq_out)
      else $error("interrupt high with all masked");
endmodule // ssm_boc_chk

bind ssm_boc_ctrl ssm_boc_chk chk (.mclk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
   .rd_data_out, .frame_tick_in, .frame_num_in, .tx_sa_out, .tx_sa_ovr_out, .tx_si_out, .irq_out);

// File: verif/e1_far_end.sv
// far-end E1 equipment and framer timing for the ssm bench
// assumes one frame every 4 clocks; code_in changes between nibbles
`timescale 1ns/100ps
module e1_far_end
(
   // clock and reset
   input wire mclk_in,
   input wire rst_in,
   // code to send
   input wire [3:0] code_in,
   input wire err_in,
   // framer side
   output reg tick_out,
   output reg [3:0] frame_out,
   output reg [4:0] sa_out,
   output reg si_out,
   output reg err_out
);
   reg [1:0] div_ff;
   reg [3:0] num_ff;
   reg [3:0] code_ff;
   wire [3:0] pos = num_ff - 4'h2;
   wire [3:0] cur = (pos[2:0] == 3'h0) ? code_in : code_ff;
   // msb first, phase 0 at frames 2 and 10
   wire bit_now = cur[~pos[2:1]];

   always @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         div_ff <= 2'h0;
         num_ff <= 4'h1;
         code_ff <= 4'h0;
         tick_out <= 1'b0;
         frame_out <= 4'h0;
         sa_out <= 5'h00;
         si_out <= 1'b0;
         err_out <= 1'b0;
      end
      else
      begin
         div_ff <= div_ff + 2'h1;
         tick_out <= (div_ff == 2'h3);
         if (div_ff == 2'h3)
         begin
            num_ff <= num_ff + 4'h1;
            code_ff <= cur;
            frame_out <= num_ff;
            sa_out <= {5{bit_now}};
            si_out <= bit_now;
            err_out <= err_in;
         end
         else
         begin
            // only valid beside the tick, so never hold a stale value
            frame_out <= ~frame_out;
            sa_out <= ~sa_out;
            si_out <= ~si_out;
            err_out <= ~err_out;
         end
      end
   end
endmodule // e1_far_end

// File: verif/testbench.sv
// self-checking bench for the ssm code controller
// assumes the far-end model makes a frame every 4 clocks
`timescale 1ns/100ps
`include "ssm_map.vh"
module testbench;
   reg mclk_in;
   reg rst_in;
   reg [8:0] addr;
   reg [7:0] wdata;
   reg wr;
   reg rd;
   reg [3:0] far_code;
   wire [7:0] rdata;
   wire tick;
   wire [3:0] fnum;
   wire [4:0] rsa;
   wire rsi;
   wire rerr;
   wire [4:0] tsa;
   wire [4:0] tovr;
   wire tsi;
   wire irq;
   integer n_errors;
   integer n_checks;

   ssm_boc_ctrl DUT (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr), .wr_data_in(wdata),
      .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .frame_tick_in(tick), .frame_num_in(fnum),
      .rx_sa_in(rsa), .rx_si_in(rsi), .rx_err_in(rerr), .tx_sa_out(tsa), .tx_sa_ovr_out(tovr),
      .tx_si_out(tsi), .irq_out(irq));
   e1_far_end far (.mclk_in(mclk_in), .rst_in(rst_in), .code_in(far_code), .err_in(1'b0),
      .tick_out(tick), .frame_out(fnum), .sa_out(rsa), .si_out(rsi), .err_out(rerr));

   // ****
   // tasks
   // ****
   task stop_test;
   begin
      if (n_errors == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   end
   endtask

   task check(input [7:0] got, input [7:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         n_errors = n_errors + 1;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task wr_reg(input [8:0] a, input [7:0] d);
   begin
      @(posedge mclk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   end
   endtask

   task rd_chk(input [8:0] a, input [7:0] e);
   begin
      @(posedge mclk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1;
      check(rdata, e);
   end
   endtask

   // returns just after the edge that launched the tick of frame f
   task wait_tick(input [3:0] f);
      integer i;
   begin
      for (i = 0; i < 200; i = i + 1)
      begin
         @(posedge mclk_in);
         #1;
         if (tick && fnum == f)
            i = 300;
      end
      if (i == 200)
      begin
         n_errors = n_errors + 1;
         stop_test;
      end
   end
   endtask

   task chk_tx(input [3:0] f0, input [15:0] pat, input integer n, input sa);
      integer k;
   begin
      for (k = 0; k < n; k = k + 1)
      begin
         wait_tick(f0 + {k[2:0], 1'b0});
         repeat (2) @(posedge mclk_in);
         #1;
         if (sa)
         begin
            check({3'h0, tsa}, {3'h0, 2'h3, pat[15 - k], 2'h3});
            check({3'h0, tovr}, 8'h04);
         end
         else
            check({7'h0, tsi}, {7'h0, pat[15 - k]});
      end
   end
   endtask

   task irq_chk(input [7:0] e);
   begin
      repeat (2) @(posedge mclk_in);
      #1;
      check({7'h0, irq}, e);
   end
   endtask

   // ****
   // scenarios
   // ****
   task t_regs;
      integer i;
   begin
      for (i = 0; i < 13; i = i + 1)
         rd_chk(9'h170 + i[8:0], (i == 6) ? `R_REPEAT : 8'h00);
      wr_reg(`A_RX_CODE, 8'hFF);
      wr_reg(9'h17C, 8'hFF);
      wr_reg(`A_MATCH_ONE, 8'hFF);
      wr_reg(`A_TX_REPEAT, 8'h05);
      wr_reg(`A_IRQ_MASK, 8'h3F);
      rd_chk(`A_RX_CODE, 8'h00);
      rd_chk(9'h17C, 8'h00);
      rd_chk(`A_MATCH_ONE, 8'h0F);
      rd_chk(`A_TX_REPEAT, 8'h05);
      wr_reg(`A_CONTROL, 8'h08);
      rd_chk(`A_TX_REPEAT, 8'h01);
      rd_chk(`A_MATCH_ONE, 8'h00);
      rd_chk(`A_IRQ_MASK, 8'h3F);
      rd_chk(`A_CONTROL, 8'h00);
      wr_reg(`A_IRQ_MASK, 8'h00);
   end
   endtask

   task t_rx;
   begin
      wr_reg(`A_MATCH_ONE, 8'h0B);
      wr_reg(`A_MATCH_TWO, 8'h02);
      wr_reg(`A_MATCH_THREE, 8'h0F);
      wait_tick(4'h0);
      wr_reg(`A_CONTROL, 8'hB2);
      wait_tick(4'h8);
      wait_tick(4'h0);
      repeat (6) @(posedge mclk_in);
      rd_chk(`A_RX_CODE, 8'h00);
      rd_chk(`A_IRQ_STATUS, 8'h00);
      wait_tick(4'h8);
      far_code <= 4'h2;
      repeat (6) @(posedge mclk_in);
      rd_chk(`A_RX_CODE, 8'h0B);
      rd_chk(`A_IRQ_STATUS, 8'h07);
      rd_chk(`A_RX_INTL, 8'hDD);
      wr_reg(`A_IRQ_STATUS, 8'h3F);
      rd_chk(`A_IRQ_STATUS, 8'h00);
      wr_reg(`A_CONTROL, 8'h90);
      wait_tick(4'h0);
      repeat (6) @(posedge mclk_in);
      rd_chk(`A_RX_CODE, 8'hB2);
      rd_chk(`A_IRQ_STATUS, 8'h0B);
      wr_reg(`A_CONTROL, 8'h80);
      far_code <= 4'hB;
      wait_tick(4'h0);
      wait_tick(4'h0);
      rd_chk(`A_RX_CODE, 8'hB2);
      wr_reg(`A_IRQ_STATUS, 8'h3F);
      wr_reg(`A_CONTROL, 8'hD6);
      wait_tick(4'h8);
      wait_tick(4'h8);
      wait_tick(4'h8);
      repeat (6) @(posedge mclk_in);
      rd_chk(`A_IRQ_STATUS, 8'h04);
      rd_chk(`A_RX_CODE, 8'hB2);
      wait_tick(4'h8);
      repeat (6) @(posedge mclk_in);
      rd_chk(`A_RX_CODE, 8'h2B);
      rd_chk(`A_IRQ_STATUS, 8'h07);
   end
   endtask

   task t_tx;
   begin
      wr_reg(`A_IRQ_STATUS, 8'h3F);
      wr_reg(`A_TX_INTL, 8'hA5);
      wait_tick(4'h0);
      chk_tx(4'h2, 16'h4B00, 8, 1'b0);
      wait_tick(4'h8);
      wr_reg(`A_TX_CODE, 8'h0B);
      wr_reg(`A_CONTROL, 8'h81);
      rd_chk(`A_CONTROL, 8'h80);
      wait_tick(4'h0);
      chk_tx(4'h2, 16'hBF00, 8, 1'b0);
      rd_chk(`A_IRQ_STATUS, 8'h20);
      wr_reg(`A_IRQ_MASK, 8'h20);
      irq_chk(8'h01);
      wr_reg(`A_IRQ_MASK, 8'h00);
      irq_chk(8'h00);
      wr_reg(`A_IRQ_MASK, 8'h20);
      wr_reg(`A_IRQ_STATUS, 8'h20);
      irq_chk(8'h00);
      wr_reg(`A_CONTROL, 8'h08);
      wr_reg(`A_SA_SELECT, 8'h02);
      wr_reg(`A_TX_REPEAT, 8'h02);
      wr_reg(`A_TX_CODE, 8'h04);
      wait_tick(4'h8);
      wr_reg(`A_CONTROL, 8'h01);
      wait_tick(4'h0);
      chk_tx(4'h3, 16'h44FF, 16, 1'b1);
      wr_reg(`A_TX_REPEAT, 8'h00);
      wr_reg(`A_CONTROL, 8'h01);
      chk_tx(4'h3, 16'h4444, 16, 1'b1);
      wr_reg(`A_TX_REPEAT, 8'h01);
      wr_reg(`A_CONTROL, 8'h01);
      chk_tx(4'h3, 16'h4F00, 8, 1'b1);
   end
   endtask

   initial
   begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end

   initial
   begin
      n_errors = 0;
      n_checks = 0;
      rst_in = 1'b1;
      addr = 9'h000;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      far_code = 4'hB;
      repeat (4) @(posedge mclk_in);
      rst_in <= 1'b0;
      t_regs;
      t_rx;
      t_tx;
      stop_test;
   end
endmodule // testbench
